/* bank1_defines.svh */
// offsets, field positions, reset values and masks of the bank-one register map
`ifndef BANK1_DEFINES_SVH
`define BANK1_DEFINES_SVH
`define OFS_INDIRECT_DATA_ACCESS 8'h80
`define OFS_TIMER_PRESCALE_CONFIG 8'h81
`define OFS_PROGRAM_COUNTER_LOW 8'h82
`define OFS_CORE_STATUS 8'h83
`define OFS_INDIRECT_POINTER 8'h84
`define OFS_PORT_A_DIRECTION 8'h85
`define OFS_PORT_B_DIRECTION 8'h86
`define OFS_PORT_C_DIRECTION 8'h87
`define OFS_PC_UPPER_LATCH 8'h8a
`define OFS_INTERRUPT_CONTROL 8'h8b
`define OFS_PERIPHERAL_IRQ_ENABLE_ONE 8'h8c
`define OFS_POWER_RESET_STATUS 8'h8e
`define OFS_TIMER2_PERIOD 8'h92
`define OFS_SERIAL_SLAVE_ADDRESS 8'h93
`define OFS_SERIAL_PORT_STATE 8'h94
`define LOC_INDIRECT 7'h00
`define LOC_PRESCALE 7'h01
`define LOC_PC_LOW 7'h02
`define LOC_STATUS 7'h03
`define LOC_POINTER 7'h04
`define LOC_PC_LATCH 7'h0a
`define LOC_IRQ_CTRL 7'h0b
`define BANK_SEL_BIT 7
`define STATUS_IND_BANK_BIT 7
`define STATUS_UPPER_BANK_BIT 6
`define STATUS_TIMEOUT_BIT 4
`define STATUS_POWERDOWN_BIT 3
`define PWR_POWERON_BIT 1
`define PWR_BROWNOUT_BIT 0
`define RST_OPTION 8'hff
`define RST_PORT_A_DIR 6'h3f
`define RST_PORT_B_DIR 8'hff
`define RST_PORT_C_DIR 8'hff
`define RST_TIMER2_PERIOD 8'hff
`define RST_IRQ_ENABLE 8'h00
`define RST_SERIAL_ADDR 8'h00
`define RST_PC_LOW 8'h00
`define RST_PC_LATCH 5'h00
`define RST_STATUS_POR 8'h18
`define MASK_STATUS_KEEP 8'h07
`define MASK_IRQ_CTRL_KEEP 8'h01
`define MASK_IRQ_ENABLE 8'hcf
`define MASK_SERIAL_STATE 8'h3f
`endif

/* bank1_pkg.sv */
// types shared by the bank-one register map
package bank1_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {RST_NONE, RST_POWER, RST_OTHER} rst_cause_t;
endpackage

/* bank1_reg8.sv */
`timescale 1ns/1ps
// register of one to eight bits with split reset values and a mask of bits kept on other resets
module bank1_reg8 #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] POWER_VAL = '0,
   parameter logic [WIDTH-1:0] OTHER_VAL = '0,
   parameter logic [WIDTH-1:0] KEEP_MASK = '0
) (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic power_rst_i,
   input wire logic other_rst_i,
   input wire logic wr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   output logic [WIDTH-1:0] q_o
);
   initial begin
      if (WIDTH < 1 || WIDTH > 8) $error("bank1_reg8: WIDTH out of range");
   end
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;
   always_comb begin
      q_nxt = q_r;
      if (power_rst_i) begin
         q_nxt = POWER_VAL;
      end else if (other_rst_i) begin
         q_nxt = (q_r & KEEP_MASK) | (OTHER_VAL & ~KEEP_MASK);
      end else if (wr_i) begin
         q_nxt = wdata_i;
      end
   end
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         q_r <= q_nxt;
      end
   end
   assign q_o = q_r;
endmodule

/* bank1_regs.sv */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
// bank-one special function register map
// How it works
// - mirrored core registers decode in both banks
// - unimplemented locations read zero, writes ignored
// - unimplemented bits always read as zero
// - indirect location redirects through the pointer
// - latch loads pc upper bits on update
// - power resets and other resets differ
// - other resets keep status bits 2:0, set cause flags
`include "bank1_defines.svh"
module bank1_regs (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic por_i,
   input wire logic brownout_i,
   input wire logic wdt_reset_i,
   input wire logic sleep_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output bank1_pkg::byte_t rdata_o,
   input wire bank1_pkg::byte_t status_flags_i,
   input wire logic status_flags_we_i,
   input wire bank1_pkg::byte_t irq_ctrl_hw_i,
   input wire logic irq_ctrl_hw_we_i,
   input wire logic [5:0] serial_state_i,
   input wire logic pc_update_i,
   input wire logic [7:0] pc_low_i,
   output logic [12:0] pc_o,
   output bank1_pkg::byte_t ind_addr_o,
   output logic ind_rd_o,
   output logic ind_wr_o,
   output bank1_pkg::byte_t ind_wdata_o,
   input wire bank1_pkg::byte_t ind_rdata_i,
   output bank1_pkg::byte_t option_o,
   output logic [5:0] port_a_direction_o,
   output bank1_pkg::byte_t port_b_direction_o,
   output bank1_pkg::byte_t port_c_direction_o,
   output bank1_pkg::byte_t peripheral_irq_enable_one_o,
   output bank1_pkg::byte_t timer2_period_o,
   output bank1_pkg::byte_t serial_slave_address_o,
   output bank1_pkg::byte_t interrupt_control_o,
   output bank1_pkg::byte_t core_status_o,
   output logic [1:0] power_reset_status_o
);
   import bank1_pkg::*;

   typedef struct packed {
      logic [1:0] por_sync;
      logic [1:0] brownout_sync;
      logic [1:0] wdt_sync;
      byte_t status;
      byte_t pointer;
      byte_t irq_ctrl;
      logic [1:0] pwr_stat;
      logic [4:0] pc_latch;
      logic [12:0] pc;
      logic pend_ind_rd;
      byte_t rdata;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   rst_cause_t cause;
   logic power_rst;
   logic other_rst;
   logic [6:0] loc;
   logic wr_hit;
   logic [7:0] rd_mux;
   byte_t option_q;
   byte_t dir_b_q;
   byte_t dir_c_q;
   byte_t irq_en_q;
   byte_t period_q;
   byte_t slave_addr_q;
   logic [5:0] dir_a_q;

   // second flop of each synchroniser only
   always_comb begin
      if (!resetn_i || s_r.por_sync[1] || s_r.brownout_sync[1]) begin
         cause = s_r.por_sync[1] || s_r.brownout_sync[1] ? RST_POWER
            : RST_OTHER;
      end else if (s_r.wdt_sync[1]) begin
         cause = RST_OTHER;
      end else begin
         cause = RST_NONE;
      end
   end
   assign power_rst = (cause == RST_POWER);
   assign other_rst = (cause == RST_OTHER);

   // bank bit dropped: mirrored and bank-one locations both decode
   assign loc = addr_i[6:0];
   assign wr_hit = wr_i && !power_rst && !other_rst;

   bank1_reg8 #(
      .WIDTH(8),
      .POWER_VAL(`RST_OPTION),
      .OTHER_VAL(`RST_OPTION)
   ) u_prescale_cfg (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .power_rst_i(power_rst),
      .other_rst_i(other_rst),
      .wr_i(wr_hit && addr_i == `OFS_TIMER_PRESCALE_CONFIG),
      .wdata_i(wdata_i),
      .q_o(option_q)
   );

   bank1_reg8 #(
      .WIDTH(6),
      .POWER_VAL(`RST_PORT_A_DIR),
      .OTHER_VAL(`RST_PORT_A_DIR)
   ) u_dir_a (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .power_rst_i(power_rst),
      .other_rst_i(other_rst),
      .wr_i(wr_hit && addr_i == `OFS_PORT_A_DIRECTION),
      .wdata_i(wdata_i[5:0]),
      .q_o(dir_a_q)
   );

   bank1_reg8 #(
      .WIDTH(8),
      .POWER_VAL(`RST_PORT_B_DIR),
      .OTHER_VAL(`RST_PORT_B_DIR)
   ) u_dir_b (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .power_rst_i(power_rst),
      .other_rst_i(other_rst),
      .wr_i(wr_hit && addr_i == `OFS_PORT_B_DIRECTION),
      .wdata_i(wdata_i),
      .q_o(dir_b_q)
   );

   bank1_reg8 #(
      .WIDTH(8),
      .POWER_VAL(`RST_PORT_C_DIR),
      .OTHER_VAL(`RST_PORT_C_DIR)
   ) u_dir_c (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .power_rst_i(power_rst),
      .other_rst_i(other_rst),
      .wr_i(wr_hit && addr_i == `OFS_PORT_C_DIRECTION),
      .wdata_i(wdata_i),
      .q_o(dir_c_q)
   );

   bank1_reg8 #(
      .WIDTH(8),
      .POWER_VAL(`RST_IRQ_ENABLE),
      .OTHER_VAL(`RST_IRQ_ENABLE)
   ) u_irq_en (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .power_rst_i(power_rst),
      .other_rst_i(other_rst),
      .wr_i(wr_hit && addr_i == `OFS_PERIPHERAL_IRQ_ENABLE_ONE),
      .wdata_i(wdata_i & `MASK_IRQ_ENABLE),
      .q_o(irq_en_q)
   );

   bank1_reg8 #(
      .WIDTH(8),
      .POWER_VAL(`RST_TIMER2_PERIOD),
      .OTHER_VAL(`RST_TIMER2_PERIOD)
   ) u_period (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .power_rst_i(power_rst),
      .other_rst_i(other_rst),
      .wr_i(wr_hit && addr_i == `OFS_TIMER2_PERIOD),
      .wdata_i(wdata_i),
      .q_o(period_q)
   );

   bank1_reg8 #(
      .WIDTH(8),
      .POWER_VAL(`RST_SERIAL_ADDR),
      .OTHER_VAL(`RST_SERIAL_ADDR)
   ) u_slave_addr (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .power_rst_i(power_rst),
      .other_rst_i(other_rst),
      .wr_i(wr_hit && addr_i == `OFS_SERIAL_SLAVE_ADDRESS),
      .wdata_i(wdata_i),
      .q_o(slave_addr_q)
   );

   // read mux for registers held in this module and its leaves
   always_comb begin
      rd_mux = 8'h00;
      if (loc == `LOC_PRESCALE && addr_i[`BANK_SEL_BIT]) begin
         rd_mux = option_q;
      end else if (loc == `LOC_PC_LOW) begin
         rd_mux = s_r.pc[7:0];
      end else if (loc == `LOC_STATUS) begin
         rd_mux = s_r.status;
      end else if (loc == `LOC_POINTER) begin
         rd_mux = s_r.pointer;
      end else if (addr_i == `OFS_PORT_A_DIRECTION) begin
         rd_mux = {2'b00, dir_a_q};
      end else if (addr_i == `OFS_PORT_B_DIRECTION) begin
         rd_mux = dir_b_q;
      end else if (addr_i == `OFS_PORT_C_DIRECTION) begin
         rd_mux = dir_c_q;
      end else if (loc == `LOC_PC_LATCH) begin
         rd_mux = {3'b000, s_r.pc_latch};
      end else if (loc == `LOC_IRQ_CTRL) begin
         rd_mux = s_r.irq_ctrl;
      end else if (addr_i == `OFS_PERIPHERAL_IRQ_ENABLE_ONE) begin
         rd_mux = irq_en_q & `MASK_IRQ_ENABLE;
      end else if (addr_i == `OFS_POWER_RESET_STATUS) begin
         rd_mux = {6'b00_0000, s_r.pwr_stat};
      end else if (addr_i == `OFS_TIMER2_PERIOD) begin
         rd_mux = period_q;
      end else if (addr_i == `OFS_SERIAL_SLAVE_ADDRESS) begin
         rd_mux = slave_addr_q;
      end else if (addr_i == `OFS_SERIAL_PORT_STATE) begin
         rd_mux = {2'b00, serial_state_i} & `MASK_SERIAL_STATE;
      end else begin
         rd_mux = 8'h00;
      end
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.por_sync = {s_r.por_sync[0], por_i};
      s_nxt.brownout_sync = {s_r.brownout_sync[0], brownout_i};
      s_nxt.wdt_sync = {s_r.wdt_sync[0], wdt_reset_i};
      s_nxt.pend_ind_rd = 1'b0;
      s_nxt.rdata = 8'h00;
      if (power_rst) begin
         s_nxt.status = `RST_STATUS_POR;
         s_nxt.irq_ctrl = 8'h00;
         s_nxt.pc_latch = `RST_PC_LATCH;
         s_nxt.pc = 13'h0000;
         s_nxt.pointer = 8'h00;
         s_nxt.pwr_stat[`PWR_POWERON_BIT] = ~s_r.por_sync[1];
         s_nxt.pwr_stat[`PWR_BROWNOUT_BIT] = ~s_r.brownout_sync[1];
      end else if (other_rst) begin
         // keep zero/carry bits, cause flags per reset source
         s_nxt.status = s_r.status & `MASK_STATUS_KEEP;
         s_nxt.status[`STATUS_TIMEOUT_BIT] = ~s_r.wdt_sync[1];
         s_nxt.status[`STATUS_POWERDOWN_BIT] = ~sleep_i;
         s_nxt.irq_ctrl = s_r.irq_ctrl & `MASK_IRQ_CTRL_KEEP;
         s_nxt.pc_latch = `RST_PC_LATCH;
         s_nxt.pc = 13'h0000;
      end else begin
         if (status_flags_we_i) begin
            s_nxt.status = status_flags_i;
         end
         if (irq_ctrl_hw_we_i) begin
            s_nxt.irq_ctrl = irq_ctrl_hw_i;
         end
         if (pc_update_i) begin
            s_nxt.pc = {s_r.pc_latch, pc_low_i};
         end
         if (wr_i) begin
            if (loc == `LOC_PC_LOW) begin
               s_nxt.pc = {s_r.pc_latch, wdata_i};
            end else if (loc == `LOC_STATUS) begin
               // cause flags are not writable by software
               s_nxt.status = {wdata_i[7:5], s_r.status[4:3],
                  wdata_i[2:0]};
            end else if (loc == `LOC_POINTER) begin
               s_nxt.pointer = wdata_i;
            end else if (loc == `LOC_PC_LATCH) begin
               s_nxt.pc_latch = wdata_i[4:0];
            end else if (loc == `LOC_IRQ_CTRL) begin
               s_nxt.irq_ctrl = wdata_i;
            end else if (addr_i == `OFS_POWER_RESET_STATUS) begin
               s_nxt.pwr_stat = wdata_i[1:0];
            end
         end
         if (rd_i) begin
            s_nxt.pend_ind_rd = (loc == `LOC_INDIRECT);
            s_nxt.rdata = rd_mux;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   // indirect location issues the pointer address to data memory
   assign ind_addr_o = s_r.pointer;
   assign ind_rd_o = rd_i && loc == `LOC_INDIRECT && !power_rst && !other_rst;
   assign ind_wr_o = wr_hit && loc == `LOC_INDIRECT;
   assign ind_wdata_o = wdata_i;
   assign rdata_o = s_r.pend_ind_rd ? ind_rdata_i : s_r.rdata;
   assign pc_o = s_r.pc;
   assign option_o = option_q;
   assign port_a_direction_o = dir_a_q;
   assign port_b_direction_o = dir_b_q;
   assign port_c_direction_o = dir_c_q;
   assign peripheral_irq_enable_one_o = irq_en_q;
   assign timer2_period_o = period_q;
   assign serial_slave_address_o = slave_addr_q;
   assign interrupt_control_o = s_r.irq_ctrl;
   assign core_status_o = s_r.status;
   assign power_reset_status_o = s_r.pwr_stat;
endmodule

/* bank1_regs_chk.sv */
// port assertions for the bank-one register map
`timescale 1ns/1ps
module bank1_regs_chk (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire bank1_pkg::byte_t rdata_o,
   input wire logic pc_update_i,
   input wire logic [7:0] pc_low_i,
   input wire logic [12:0] pc_o,
   input wire bank1_pkg::byte_t ind_addr_o,
   input wire logic ind_rd_o,
   input wire logic ind_wr_o,
   input wire bank1_pkg::byte_t option_o,
   input wire bank1_pkg::byte_t timer2_period_o,
   input wire bank1_pkg::byte_t peripheral_irq_enable_one_o,
   input wire bank1_pkg::byte_t core_status_o
);
   import bank1_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   property p_rd_idle;
      ce_i && !rd_i |=> rdata_o == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("stray read data");
   property p_unmapped;
      rd_i && ce_i && addr_i >= 8'h95 && addr_i <= 8'h9f |=> rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("hole not zero");
   property p_pie_zero;
      peripheral_irq_enable_one_o[5:4] == 2'b00;
   endproperty
   a_pie_zero: assert property (p_pie_zero)
      else $error("enable gap set");
   property p_mirror;
      rd_i && ce_i && addr_i[6:0] == 7'h03 |=> rdata_o == $past(core_status_o);
   endproperty
   a_mirror: assert property (p_mirror)
      else $error("status read wrong");
   property p_ind_strobe;
      (wr_i || rd_i) && ce_i && addr_i[6:0] == 7'h00
         |-> ind_rd_o == rd_i && ind_wr_o == wr_i;
   endproperty
   a_ind_strobe: assert property (p_ind_strobe)
      else $error("no redirect");
   property p_ind_ptr;
      wr_i && ce_i && addr_i[6:0] == 7'h04 |=> ind_addr_o == $past(wdata_i);
   endproperty
   a_ind_ptr: assert property (p_ind_ptr)
      else $error("pointer not used");
   property p_pc;
      pc_update_i && ce_i |=> pc_o[7:0] == $past(pc_low_i);
   endproperty
   a_pc: assert property (p_pc) else $error("pc low not loaded");
   property p_rst;
      $rose(resetn_i) && $past(ce_i) |-> option_o == 8'hff
         && timer2_period_o == 8'hff;
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset value wrong");
endmodule
bind bank1_regs bank1_regs_chk i_bank1_regs_chk (.clk_i, .resetn_i, .ce_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pc_update_i, .pc_low_i, .pc_o,
   .ind_addr_o, .ind_rd_o, .ind_wr_o, .option_o, .timer2_period_o,
   .peripheral_irq_enable_one_o, .core_status_o);

/* test_bank1_regs.sv */
// self-checking bench for the bank-one register map
`timescale 1ns/1ps
module test_bank1_regs;
   import bank1_pkg::*;
   logic clk_i = 0, resetn_i = 0, ce_i = 1, por_i = 1, brownout_i = 0;
   logic wdt_reset_i = 0, sleep_i = 0, wr_i = 0, rd_i = 0, pc_update_i = 0;
   logic status_flags_we_i = 0, irq_ctrl_hw_we_i = 0, ind_rd_o, ind_wr_o;
   logic [7:0] addr_i = 0, wdata_i = 0, pc_low_i = 0, d;
   logic [5:0] serial_state_i = 6'h2a, port_a_direction_o;
   logic [12:0] pc_o;
   logic [1:0] power_reset_status_o;
   byte_t status_flags_i = 0, irq_ctrl_hw_i = 0, ind_rdata_i = 8'h99;
   byte_t rdata_o, ind_addr_o, ind_wdata_o, option_o, port_b_direction_o;
   byte_t port_c_direction_o, peripheral_irq_enable_one_o, timer2_period_o;
   byte_t serial_slave_address_o, interrupt_control_o, core_status_o;
   int fails = 0, comparisons = 0;
   // write addr, read addr, write data, expected read
   logic [31:0] rows [20] = '{32'h8181_a5a5, 32'h8585_ff3f, 32'h8686_5a5a,
      32'h8787_c3c3, 32'h8a8a_ff1f, 32'h8c8c_3f0f, 32'h8e8e_0303,
      32'h9292_4040, 32'h9393_7e7e, 32'h9494_ff2a, 32'h8888_ff00,
      32'h8d8d_ff00, 32'h9090_ff00, 32'h9595_ff00, 32'h9f9f_ff00,
      32'h0a8a_0c0c, 32'h8404_3737, 32'h8b0b_8181, 32'h0101_ff00,
      32'h0080_5599};
   bank1_regs i_bank1_regs (.clk_i, .resetn_i, .ce_i, .por_i, .brownout_i,
      .wdt_reset_i, .sleep_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .status_flags_i, .status_flags_we_i, .irq_ctrl_hw_i, .irq_ctrl_hw_we_i,
      .serial_state_i, .pc_update_i, .pc_low_i, .pc_o, .ind_addr_o, .ind_rd_o,
      .ind_wr_o, .ind_wdata_o, .ind_rdata_i, .option_o, .port_a_direction_o,
      .port_b_direction_o, .port_c_direction_o, .peripheral_irq_enable_one_o,
      .timer2_period_o, .serial_slave_address_o, .interrupt_control_o,
      .core_status_o, .power_reset_status_o);
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   task summarize;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task acc(input logic w, input logic r, input logic [7:0] a, input byte_t v);
      @(posedge clk_i);
      wr_i <= w;
      rd_i <= r;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 0;
      rd_i <= 0;
      #1 d = rdata_o;
   endtask
   // hold a reset source for four cycles, then let the syncs drain
   task pulse(input int src);
      @(posedge clk_i);
      if (src == 0) resetn_i <= 0;
      if (src == 1) wdt_reset_i <= 1;
      if (src == 2) por_i <= 1;
      if (src == 3) brownout_i <= 1;
      repeat (4) @(posedge clk_i);
      resetn_i <= 1;
      wdt_reset_i <= 0;
      por_i <= 0;
      brownout_i <= 0;
      repeat (6) @(posedge clk_i);
      #1;
   endtask
   initial begin
      #100000;
      fails++;
      summarize;
   end
   initial begin
      // power-on first, drained through its sync before the pin reset ends
      repeat (10) @(posedge clk_i);
      por_i <= 0;
      repeat (10) @(posedge clk_i);
      resetn_i <= 1;
      foreach (rows[i]) begin
         acc(1, 0, rows[i][31:24], rows[i][15:8]);
         acc(0, 1, rows[i][23:16], 8'h00);
         chk(d, rows[i][7:0]);
      end
      chk(ind_addr_o, 8'h37);
      @(posedge clk_i);
      pc_low_i <= 8'h34;
      pc_update_i <= 1;
      status_flags_i <= 8'h05;
      status_flags_we_i <= 1;
      @(posedge clk_i);
      pc_update_i <= 0;
      status_flags_we_i <= 0;
      #1 chk(pc_o, 13'h0c34);
      acc(0, 1, 8'h03, 8'h00);
      chk(d, 8'h05);
      sleep_i <= 1;
      pulse(0);
      sleep_i <= 0;
      chk(core_status_o, 8'h15);
      chk(interrupt_control_o, 8'h01);
      chk({option_o, timer2_period_o}, 16'hffff);
      chk({port_b_direction_o, port_c_direction_o}, 16'hffff);
      chk(port_a_direction_o, 6'h3f);
      chk({peripheral_irq_enable_one_o, serial_slave_address_o}, 0);
      chk(power_reset_status_o, 2'b11);
      pulse(1);
      chk(core_status_o, 8'h0d);
      pulse(2);
      chk(core_status_o, 8'h18);
      chk(power_reset_status_o, 2'b01);
      acc(1, 0, 8'h8e, 8'h03);
      pulse(3);
      chk(power_reset_status_o, 2'b10);
      chk(pc_o, 13'h0000);
      // write while frozen must not land
      ce_i <= 0;
      acc(1, 0, 8'h92, 8'h11);
      ce_i <= 1;
      chk(timer2_period_o, 8'hff);
      @(posedge clk_i);
      wr_i <= 1;
      addr_i <= 8'h80;
      wdata_i <= 8'h66;
      #1 chk({6'h00, ind_wr_o, ind_rd_o, ind_wdata_o}, 16'h0266);
      @(posedge clk_i);
      wr_i <= 0;
      summarize;
   end
endmodule
